// ==== pkg/swl_if.sv ====
// Open-drain single-wire line joining the controller and the device
interface swl_if;
    timeunit 1ns;
    timeprecision 1ps;
    logic ctl_oe;
    logic dev_oe;
    logic line_i;
    // Wired-AND: any enabled driver pulls low, else pulled up
    assign line_i = ~(ctl_oe | dev_oe);
    modport ctl (output ctl_oe, input line_i);
    modport dev (output dev_oe, input line_i);
endinterface

// ==== pkg/swl_pkg.sv ====
// Shared timing, command codes and sequencer states for the single-wire link
// Summary of operation
// [RULE1] Controller releases line early for written one
// [RULE2] Controller holds line low for written zero
// [RULE3] Recovery interval needed before next slot
// [RULE4] Read slot: controller holds low read time
// [RULE5] Device pulls low within read time for zero
// [RULE6] Device never pulls low when returning one
// [RULE7] Controller samples inside sampling window
// [RULE8] Controller waits full slot after sampling
// [RULE9] Eight-bit selection command after presence
// [RULE10] Search walks identifier LSB first, triplets
// [RULE11] Search sends true bit then complement
// [RULE12] Mismatching written bit drops device from search
// [RULE13] Identifier read sends family, serial, CRC
// [RULE14] Match selects only on exact identifier
// [RULE15] Skip goes straight to function commands
// [RULE16] Resume proceeds when resume flag set
// [RULE17] Resume flag set by successful match/search
// [RULE18] Resume flag cleared when another device accessed
// [RULE19] Reset and presence start every transaction
// [RULE20] Idle high; long low resets devices
// [RULE21] Match identifier sent LSB first
// [RULE22] Unknown command ignored until next reset
package swl_pkg;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned CLK_MHZ          = 250;
    // Times in nanoseconds
    localparam int unsigned WRITE_ONE_LOW_MAX_NS  = 2000;
    localparam int unsigned WRITE_ZERO_LOW_MIN_NS = 6000;
    localparam int unsigned SLOT_RECOVERY_NS      = 1000;
    localparam int unsigned READ_LOW_TIME_NS      = 1000;
    localparam int unsigned DEV_SAMPLE_NS         = 3000;
    localparam int unsigned DEV_HOLD_NS           = 4000;
    localparam int unsigned SAMPLE_WINDOW_NS      = 1500;
    localparam int unsigned SLOT_DURATION_NS      = 10000;
    localparam int unsigned RESET_DETECT_NS       = 16000;
    // Reset pulse sits just above the detect time so slot traffic dominates run time
    localparam int unsigned RESET_LOW_NS          = 18000;
    localparam int unsigned PRESENCE_WAIT_NS      = 2000;
    localparam int unsigned PRESENCE_LOW_NS       = 8000;
    localparam int unsigned PRESENCE_SAMPLE_NS    = 5000;
    // Covers presence wait and pull plus slot recovery
    localparam int unsigned RESET_HIGH_NS         = 12000;
    // Cycle counts: minima round up, maxima round down
    localparam int unsigned W1_LOW_CYC  = (WRITE_ONE_LOW_MAX_NS * CLK_MHZ) / 1000;
    localparam int unsigned W0_LOW_CYC  = (WRITE_ZERO_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned REC_CYC     = (SLOT_RECOVERY_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RL_CYC      = (READ_LOW_TIME_NS * CLK_MHZ) / 1000;
    localparam int unsigned DSAMP_CYC   = (DEV_SAMPLE_NS * CLK_MHZ) / 1000;
    localparam int unsigned DHOLD_CYC   = (DEV_HOLD_NS * CLK_MHZ) / 1000;
    localparam int unsigned MSAMP_CYC   = (SAMPLE_WINDOW_NS * CLK_MHZ) / 1000;
    localparam int unsigned SLOT_CYC    = (SLOT_DURATION_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RSTDET_CYC  = (RESET_DETECT_NS * CLK_MHZ) / 1000;
    localparam int unsigned RSTL_CYC    = (RESET_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PDH_CYC     = (PRESENCE_WAIT_NS * CLK_MHZ) / 1000;
    localparam int unsigned PDL_CYC     = (PRESENCE_LOW_NS * CLK_MHZ) / 1000;
    localparam int unsigned MSP_CYC     = (PRESENCE_SAMPLE_NS * CLK_MHZ) / 1000;
    localparam int unsigned RSTH_CYC    = (RESET_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W       = 16;
    // Selection command codes
    localparam logic [7:0] CMD_SEARCH = 8'hf0;
    localparam logic [7:0] CMD_READ   = 8'h33;
    localparam logic [7:0] CMD_MATCH  = 8'h55;
    localparam logic [7:0] CMD_SKIP   = 8'hcc;
    localparam logic [7:0] CMD_RESUME = 8'ha5;
    localparam int unsigned ID_BITS   = 64;

    typedef enum logic [2:0] {
        SWL_WAIT_RST = 3'b000,
        SWL_CMD      = 3'b001,
        SWL_SEARCH   = 3'b010,
        SWL_READ     = 3'b011,
        SWL_MATCH    = 3'b100,
        SWL_FUNC     = 3'b101
    } swl_phase_e;

    typedef enum logic [2:0] {
        SWH_IDLE   = 3'b000,
        SWH_RSTLOW = 3'b001,
        SWH_RSTHI  = 3'b010,
        SWH_LOW    = 3'b011,
        SWH_HIGH   = 3'b100
    } swl_hst_e;
endpackage

// ==== src/swl_controller.sv ====
// Controller end: reset pulse, presence check and one-bit slots
module swl_controller (
    input  wire logic mclk,
    input  wire logic rst,
    swl_if.ctl        bus,
    input  wire logic req_reset,
    input  wire logic req_bit,
    input  wire logic wr_bit,
    output logic      ready,
    output logic      done,
    output logic      rd_bit,
    output logic      presence
);
    timeunit 1ns;
    timeprecision 1ps;
    import swl_pkg::*;

    typedef struct packed {
        swl_hst_e         st;
        logic [CNT_W-1:0] cnt;
        logic             wbit;
        logic             rbit;
        logic             pres;
        logic             done;
    } swl_ctl_s;

    swl_ctl_s cur_ff;
    swl_ctl_s nxt_ff;

    always_comb begin
        nxt_ff      = cur_ff;
        nxt_ff.done = 1'b0;
        nxt_ff.cnt  = cur_ff.cnt + 1'b1;
        unique case (cur_ff.st)
            SWH_IDLE: begin
                nxt_ff.cnt = '0; // RULE20
                if (req_reset) nxt_ff.st = SWH_RSTLOW;
                else if (req_bit) begin
                    nxt_ff.st   = SWH_LOW;
                    nxt_ff.wbit = wr_bit;
                end
            end
            SWH_RSTLOW: if (cur_ff.cnt == CNT_W'(RSTL_CYC)) begin // RULE19
                nxt_ff.st = SWH_RSTHI;
                nxt_ff.cnt = '0;
            end
            SWH_RSTHI: begin
                if (cur_ff.cnt == CNT_W'(MSP_CYC)) nxt_ff.pres = ~bus.line_i;
                if (cur_ff.cnt == CNT_W'(RSTH_CYC)) begin
                    nxt_ff.st = SWH_IDLE;
                    nxt_ff.done = 1'b1;
                end
            end
            SWH_LOW: begin
                // One and read release early; zero holds long
                if (cur_ff.cnt == CNT_W'(cur_ff.wbit ? (W1_LOW_CYC < RL_CYC ? W1_LOW_CYC
                        : RL_CYC) : W0_LOW_CYC)) begin // RULE1 RULE2 RULE4
                    nxt_ff.st = SWH_HIGH;
                end
            end
            SWH_HIGH: begin
                if (cur_ff.cnt == CNT_W'(MSAMP_CYC)) nxt_ff.rbit = bus.line_i; // RULE7
                // Full slot plus recovery before next slot
                if (cur_ff.cnt == CNT_W'(SLOT_CYC + REC_CYC)) begin // RULE3 RULE8
                    nxt_ff.st = SWH_IDLE;
                    nxt_ff.done = 1'b1;
                end
            end
            default: nxt_ff.st = SWH_IDLE;
        endcase
    end

    // One register holds the whole state
    always_ff @(posedge mclk) begin
        if (rst) begin
            cur_ff    <= '0;
            cur_ff.st <= SWH_IDLE;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign bus.ctl_oe = cur_ff.st == SWH_RSTLOW || cur_ff.st == SWH_LOW;
    assign ready      = cur_ff.st == SWH_IDLE;
    assign done       = cur_ff.done;
    assign rd_bit     = cur_ff.rbit;
    assign presence   = cur_ff.pres;
endmodule

// ==== src/swl_device.sv ====
// Peripheral end: slot timing, presence and identifier selection commands
module swl_device #(
    parameter logic [63:0] UNIQUE_IDENTIFIER = 64'h5a00_0000_1234_5601 // Arbitrary value
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    swl_if.dev                 bus,
    output logic               selected,
    output logic               resume_flag,
    input  wire logic          other_accessed
);
    timeunit 1ns;
    timeprecision 1ps;
    import swl_pkg::*;

    typedef struct packed {
        swl_phase_e      phase;
        logic [CNT_W-1:0] lowcnt;
        logic [CNT_W-1:0] slotcnt;
        logic            in_slot;
        logic            line_q;
        logic            pres_pend;
        logic [CNT_W-1:0] prescnt;
        logic            pull;
        logic [6:0]      bitcnt;
        logic [1:0]      trip;
        logic [7:0]      cmd;
        logic            match_ok;
        logic            resume_flag;
    } swl_dev_s;

    swl_dev_s cur_ff;
    swl_dev_s nxt_ff;

    // Bit to send on a read slot in the current phase
    function automatic logic send_bit(swl_dev_s s);
        logic b;
        b = UNIQUE_IDENTIFIER[s.bitcnt[5:0]];
        if (s.phase == SWL_SEARCH && s.trip == 2'd1) begin
            send_bit = ~b; // RULE11
        end else begin
            send_bit = b;
        end
    endfunction

    // Next state of the whole device, worked out from the line each cycle
    always_comb begin
        logic fall;
        logic sample;
        logic ib;
        logic set_rf;
        fall   = cur_ff.line_q & ~bus.line_i;
        sample = cur_ff.in_slot && cur_ff.slotcnt == CNT_W'(DSAMP_CYC);
        ib     = bus.line_i;
        set_rf = 1'b0;
        nxt_ff = cur_ff;
        nxt_ff.line_q = bus.line_i;
        // Low-time counter for reset detection
        nxt_ff.lowcnt = bus.line_i ? '0 : cur_ff.lowcnt + 1'b1;
        nxt_ff.slotcnt = cur_ff.in_slot ? cur_ff.slotcnt + 1'b1 : '0;
        if (fall && !cur_ff.in_slot && !cur_ff.pres_pend) begin
            nxt_ff.in_slot = 1'b1;
            nxt_ff.slotcnt = '0;
            // Zero reply: pull at once, well inside read low time
            if (cur_ff.phase == SWL_READ || (cur_ff.phase == SWL_SEARCH && cur_ff.trip != 2'd2))
                nxt_ff.pull = ~send_bit(cur_ff); // RULE5 RULE6
        end
        if (cur_ff.in_slot && cur_ff.slotcnt == CNT_W'(DHOLD_CYC)) begin
            nxt_ff.pull    = 1'b0;
            nxt_ff.in_slot = 1'b0; // RULE3
        end
        if (sample) begin
            unique case (cur_ff.phase)
                SWL_CMD: begin
                    nxt_ff.cmd    = {ib, cur_ff.cmd[7:1]};
                    nxt_ff.bitcnt = cur_ff.bitcnt + 1'b1;
                    if (cur_ff.bitcnt == 7'd7) begin // RULE9
                        nxt_ff.bitcnt = '0;
                        unique case ({ib, cur_ff.cmd[7:1]})
                            CMD_SEARCH: nxt_ff.phase = SWL_SEARCH; // RULE10
                            CMD_READ:   nxt_ff.phase = SWL_READ;
                            CMD_MATCH:  nxt_ff.phase = SWL_MATCH;
                            CMD_SKIP:   nxt_ff.phase = SWL_FUNC; // RULE15
                            CMD_RESUME: nxt_ff.phase = cur_ff.resume_flag ? SWL_FUNC
                                                                          : SWL_WAIT_RST; // RULE16
                            default:    nxt_ff.phase = SWL_WAIT_RST; // RULE22
                        endcase
                    end
                end
                SWL_SEARCH: begin
                    nxt_ff.trip = cur_ff.trip + 1'b1;
                    if (cur_ff.trip == 2'd2) begin
                        nxt_ff.trip   = '0;
                        nxt_ff.bitcnt = cur_ff.bitcnt + 1'b1;
                        if (ib != UNIQUE_IDENTIFIER[cur_ff.bitcnt[5:0]])
                            nxt_ff.phase = SWL_WAIT_RST; // RULE12
                        else if (cur_ff.bitcnt == 7'(ID_BITS - 1)) begin
                            nxt_ff.phase       = SWL_FUNC;
                            nxt_ff.resume_flag = 1'b1; // RULE17
                            set_rf             = 1'b1;
                        end
                    end
                end
                SWL_READ: begin
                    nxt_ff.bitcnt = cur_ff.bitcnt + 1'b1; // RULE13
                    if (cur_ff.bitcnt == 7'(ID_BITS - 1))
                        nxt_ff.phase = SWL_FUNC;
                end
                SWL_MATCH: begin
                    nxt_ff.bitcnt = cur_ff.bitcnt + 1'b1; // RULE21
                    nxt_ff.match_ok = cur_ff.match_ok &
                                      (ib == UNIQUE_IDENTIFIER[cur_ff.bitcnt[5:0]]);
                    if (cur_ff.bitcnt == 7'(ID_BITS - 1)) begin
                        if (nxt_ff.match_ok) begin
                            nxt_ff.phase       = SWL_FUNC;
                            nxt_ff.resume_flag = 1'b1; // RULE14 RULE17
                            set_rf             = 1'b1;
                        end else begin
                            nxt_ff.phase       = SWL_WAIT_RST;
                            nxt_ff.resume_flag = 1'b0; // RULE18
                        end
                    end
                end
                default: ;
            endcase
        end
        // Another device addressed: drop resume flag, set wins
        // A set in this cycle wins even when the flag was already up
        if (other_accessed && !set_rf)
            nxt_ff.resume_flag = 1'b0; // RULE18
        // Long low resets the link; presence follows release
        if (cur_ff.lowcnt == CNT_W'(RSTDET_CYC)) begin // RULE20
            nxt_ff.phase     = SWL_CMD; // RULE19
            nxt_ff.pres_pend = 1'b1;
            nxt_ff.prescnt   = '0;
            nxt_ff.in_slot   = 1'b0;
            nxt_ff.pull      = 1'b0;
            nxt_ff.bitcnt    = '0;
            nxt_ff.trip      = '0;
            nxt_ff.match_ok  = 1'b1;
        end
        if (cur_ff.pres_pend && (bus.line_i || cur_ff.pull)) begin
            nxt_ff.prescnt = cur_ff.prescnt + 1'b1;
            if (cur_ff.prescnt == CNT_W'(PDH_CYC))
                nxt_ff.pull = 1'b1; // RULE19
            if (cur_ff.prescnt == CNT_W'(PDH_CYC + PDL_CYC)) begin
                nxt_ff.pull      = 1'b0;
                nxt_ff.pres_pend = 1'b0;
            end
        end
    end

    // One register holds the whole state
    always_ff @(posedge mclk) begin
        if (rst) begin
            cur_ff          <= '0;
            cur_ff.phase    <= SWL_WAIT_RST;
            cur_ff.line_q   <= 1'b1;
            cur_ff.match_ok <= 1'b1;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign bus.dev_oe  = cur_ff.pull;
    assign selected    = cur_ff.phase == SWL_FUNC;
    assign resume_flag = cur_ff.resume_flag;
endmodule

// ==== verification/single_wire_slot_rom_select_tb.sv ====
// Testbench joining both ends: reset, skip, identifier read and resume over the line
module single_wire_slot_rom_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import swl_pkg::*;

    // Arbitrary value; low nibble mixes ones and zeros so both replies occur
    localparam logic [63:0] TB_ID = 64'h0123_4567_89ab_cd5a;

    logic mclk;
    logic rst;
    logic req_reset;
    logic req_bit;
    logic wr_bit;
    logic other_accessed;
    logic ready;
    logic done;
    logic rd_bit;
    logic presence;
    logic selected;
    logic resume_flag;
    logic r;
    int   n_errors;
    int   cmp_count;
    int   cyc_count = 0;
    int   lowc;

    swl_if link ();

    swl_device #(.UNIQUE_IDENTIFIER(TB_ID)) u_swl_device (
        .mclk(mclk), .rst(rst), .bus(link), .selected(selected),
        .resume_flag(resume_flag), .other_accessed(other_accessed));

    swl_controller u_swl_controller (
        .mclk(mclk), .rst(rst), .bus(link), .req_reset(req_reset), .req_bit(req_bit),
        .wr_bit(wr_bit), .ready(ready), .done(done), .rd_bit(rd_bit), .presence(presence));

    swl_link_monitor u_swl_link_monitor (
        .mclk(mclk), .rst(rst), .ctl_oe(link.ctl_oe), .dev_oe(link.dev_oe),
        .line_i(link.line_i));

    // 250 MHz clock
    initial mclk = 1'b0;
    always #2 mclk = ~mclk;

    task automatic chk(input logic seen, input logic exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One slot; counts low cycles on the line so the wire itself is judged
    task automatic slot(input logic b);
        lowc = 0;
        wr_bit <= b;
        req_bit <= 1'b1;
        @(posedge mclk);
        req_bit <= 1'b0;
        for (int k = 0; k < 4000; k++) begin
            @(posedge mclk);
            if (link.line_i === 1'b0) lowc++;
            if (done === 1'b1) break;
        end
        chk(done, 1'b1, "slot never finished");
        r = rd_bit;
    endtask

    task automatic line_reset;
        req_reset <= 1'b1;
        @(posedge mclk);
        req_reset <= 1'b0;
        for (int k = 0; k < 30000; k++) begin
            @(posedge mclk);
            if (done === 1'b1) break;
        end
        chk(done, 1'b1, "reset sequence never finished");
        chk(presence, 1'b1, "no presence after reset pulse");
    endtask

    // Commands go out least significant bit first
    task automatic send_byte(input logic [7:0] c);
        for (int i = 0; i < 8; i++) begin
            slot(c[i]);
            chk(c[i] ? (lowc <= W1_LOW_CYC) : (lowc >= W0_LOW_CYC), 1'b1, "slot low time");
        end
    endtask

    // Skip, identifier read of the low nibble, then resume with the flag clear
    initial begin
        rst = 1'b1;
        req_reset = 1'b0;
        req_bit = 1'b0;
        wr_bit = 1'b0;
        other_accessed = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(link.line_i, 1'b1, "line not idle high");
        chk(selected, 1'b0, "selected straight after reset");
        line_reset();
        send_byte(CMD_SKIP);
        chk(selected, 1'b1, "skip did not select");
        chk(resume_flag, 1'b0, "skip set the resume flag");
        line_reset();
        chk(selected, 1'b0, "reset pulse kept selection");
        send_byte(CMD_READ);
        for (int i = 0; i < 4; i++) begin
            slot(1'b1);
            chk(r, TB_ID[i], "identifier bit wrong");
        end
        chk(resume_flag, 1'b0, "identifier read set the resume flag");
        line_reset();
        send_byte(CMD_RESUME);
        chk(selected, 1'b0, "resume selected with the flag clear");
        chk(resume_flag, 1'b0, "resume flag up without a match");
        final_report();
    end

    // Hang guard sized above the roughly 99.6k cycles the run needs
    always @(posedge mclk) begin
        cyc_count++;
        if (cyc_count == 103000) begin
            n_errors++;
            final_report();
        end
    end
endmodule

// ==== verification/swl_link_monitor.sv ====
// Checker for the open-drain line shared by the controller and device ends
module swl_link_monitor
    import swl_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ctl_oe,
    input wire logic dev_oe,
    input wire logic line_i
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] ctl_cnt_ff;
    logic [15:0] dev_cnt_ff;
    logic [15:0] lo_cnt_ff;
    logic [15:0] hi_cnt_ff;
    logic [15:0] last_lo_ff;

    // Saturate so a long idle never wraps into a short-looking gap
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    // Run lengths of each pull and of both line levels
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_cnt_ff <= 16'h0000;
            dev_cnt_ff <= 16'h0000;
            lo_cnt_ff  <= 16'h0000;
            hi_cnt_ff  <= 16'hffff;
            last_lo_ff <= 16'h0000;
        end else begin
            ctl_cnt_ff <= ctl_oe ? sat_inc(ctl_cnt_ff) : 16'h0000;
            dev_cnt_ff <= dev_oe ? sat_inc(dev_cnt_ff) : 16'h0000;
            lo_cnt_ff  <= line_i ? 16'h0000 : sat_inc(lo_cnt_ff);
            hi_cnt_ff  <= line_i ? sat_inc(hi_cnt_ff) : 16'h0000;
            if (line_i && lo_cnt_ff != 16'h0000) begin
                last_lo_ff <= lo_cnt_ff;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    ctl_low_bound_a: assert property (ctl_cnt_ff <= RSTL_CYC + 1)
        else $error("controller holds the line low past a reset pulse");
    rst_quiet_a: assert property ($fell(rst) |-> !ctl_oe && !dev_oe)
        else $error("line pulled right after reset release");
    ctl_pulse_a: assert property ($fell(ctl_oe) |-> ctl_cnt_ff <= W1_LOW_CYC
        || (ctl_cnt_ff >= W0_LOW_CYC && ctl_cnt_ff < RSTDET_CYC) || ctl_cnt_ff >= RSTL_CYC)
        else $error("controller low pulse of illegal length");
    slot_recovery_a: assert property ($rose(ctl_oe) |-> hi_cnt_ff >= REC_CYC)
        else $error("slot started before recovery time");
    zero_reply_a: assert property ($rose(dev_oe) && !$past(line_i) |-> lo_cnt_ff <= RL_CYC)
        else $error("zero reply pull starts too late");
    presence_cause_a: assert property ($rose(dev_oe) && $past(line_i)
        |-> last_lo_ff >= RSTDET_CYC)
        else $error("device pulled a high line without a reset pulse");
    presence_gap_a: assert property ($rose(dev_oe) && $past(line_i)
        |-> hi_cnt_ff >= PDH_CYC - 8 && hi_cnt_ff <= PDH_CYC + 8)
        else $error("presence pull at wrong delay");
    dev_hold_a: assert property (dev_cnt_ff <= PDL_CYC + 2)
        else $error("device holds the line low too long");

    // Main traffic seen on the line
    cover property ($fell(ctl_oe) && ctl_cnt_ff >= RSTL_CYC);
    cover property ($fell(ctl_oe) && ctl_cnt_ff >= W0_LOW_CYC && ctl_cnt_ff < RSTDET_CYC);
    cover property ($rose(dev_oe) && !$past(line_i));
    cover property ($rose(dev_oe) && $past(line_i));
endmodule
